/* File: rtl/dcs_diag_status.sv */
// Purpose: Read-only diagnostic completion status register on AXI4-Lite
// Assumes: Go strobes and done pulses are one-cycle, synchronous to aclk
// Notes: Writes are answered with SLVERR; unmapped reads give SLVERR and zero
`timescale 1ns/100ps
`include "dcs_consts.svh"
module dcs_diag_status (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic temp_cmp_go,
   input wire logic [1:0] temp_cmp_mode,
   input wire logic volt_cmp_go,
   input wire logic [1:0] volt_cmp_mode,
   input wire logic supply_selftest_go,
   input wire logic temp_rr_pass_done,
   input wire logic volt_rr_pass_done,
   input wire logic temp_selftest_cycle_done,
   input wire logic volt_selftest_cycle_done,
   input wire logic supply_selftest_cycle_done,
   output logic [7:0] diag_ready_status
);

   // Next flag value; completion wins over a launch in the same cycle
   function automatic logic flag_next(input logic cur, input logic clr, input logic set);
      flag_next = set | (cur & ~clr);
   endfunction : flag_next

   dcs_pkg::dcs_stat_t stat_q;
   dcs_pkg::dcs_stat_t stat_d;
   logic awready_q;
   logic wready_q;
   logic aw_got_q;
   logic w_got_q;
   logic bvalid_q;
   logic arready_q;
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;
   logic [1:0] bresp_q;

   wire clr_temp_rr = temp_cmp_go && (temp_cmp_mode == `DCS_MODE_RR);
   wire clr_volt_rr = volt_cmp_go && (volt_cmp_mode == `DCS_MODE_RR);
   wire clr_temp_st = temp_cmp_go && (temp_cmp_mode == `DCS_MODE_ST);
   wire clr_volt_st = volt_cmp_go && (volt_cmp_mode == `DCS_MODE_ST);

   always_comb begin
      stat_d = stat_q;
      stat_d[`DCS_BIT_TEMP_RR] = flag_next(stat_q[`DCS_BIT_TEMP_RR], clr_temp_rr, temp_rr_pass_done);
      stat_d[`DCS_BIT_VOLT_RR] = flag_next(stat_q[`DCS_BIT_VOLT_RR], clr_volt_rr, volt_rr_pass_done);
      stat_d[`DCS_BIT_TEMP_ST] = flag_next(stat_q[`DCS_BIT_TEMP_ST], clr_temp_st, temp_selftest_cycle_done);
      stat_d[`DCS_BIT_VOLT_ST] = flag_next(stat_q[`DCS_BIT_VOLT_ST], clr_volt_st, volt_selftest_cycle_done);
      stat_d[`DCS_BIT_SUPPLY_ST] = flag_next(stat_q[`DCS_BIT_SUPPLY_ST], supply_selftest_go,
                                             supply_selftest_cycle_done);
      stat_d[7:5] = 3'h0;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stat_q <= `DCS_STAT_RESET;
      end else begin
         stat_q <= stat_d;
      end
   end

   // Write side: accept address and data in either order, then respond
   wire aw_fire = s_axi_awvalid && awready_q;
   wire w_fire = s_axi_wvalid && wready_q;
   wire aw_have = aw_got_q || aw_fire;
   wire w_have = w_got_q || w_fire;
   wire b_start = aw_have && w_have && !bvalid_q;
   wire b_done = bvalid_q && s_axi_bready;

   // Write address channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_q <= 1'h1;
         aw_got_q <= 1'h0;
      end else if (b_start) begin
         awready_q <= 1'h0;
         aw_got_q <= 1'h0;
      end else if (aw_fire) begin
         awready_q <= 1'h0;
         aw_got_q <= 1'h1;
      end else if (b_done) begin
         awready_q <= 1'h1;
      end
   end

   // Write data channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wready_q <= 1'h1;
         w_got_q <= 1'h0;
      end else if (b_start) begin
         wready_q <= 1'h0;
         w_got_q <= 1'h0;
      end else if (w_fire) begin
         wready_q <= 1'h0;
         w_got_q <= 1'h1;
      end else if (b_done) begin
         wready_q <= 1'h1;
      end
   end

   // Write response: every write is refused
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_q <= 1'h0;
         bresp_q <= `DCS_RESP_OKAY;
      end else if (b_start) begin
         bvalid_q <= 1'h1;
         bresp_q <= `DCS_RESP_SLVERR;
      end else if (b_done) begin
         bvalid_q <= 1'h0;
      end
   end

   // Read side: one outstanding read
   wire ar_fire = s_axi_arvalid && arready_q;
   wire ar_hit = (s_axi_araddr[`DCS_ADDR_W-1:0] == `DCS_ADDR_DIAG_READY_STATUS) &&
                 (s_axi_araddr[31:`DCS_ADDR_W] == 18'h00000);
   wire r_done = rvalid_q && s_axi_rready;
   wire [31:0] rdata_sel = ar_hit ? {24'h000000, stat_q} : 32'h00000000;
   wire [1:0] rresp_sel = ar_hit ? `DCS_RESP_OKAY : `DCS_RESP_SLVERR;

   // Read handshake
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'h1;
         rvalid_q <= 1'h0;
      end else if (ar_fire) begin
         arready_q <= 1'h0;
         rvalid_q <= 1'h1;
      end else if (r_done) begin
         arready_q <= 1'h1;
         rvalid_q <= 1'h0;
      end
   end

   // Read data, loaded as the address is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rdata_q <= 32'h00000000;
         rresp_q <= `DCS_RESP_OKAY;
      end else if (ar_fire) begin
         rdata_q <= rdata_sel;
         rresp_q <= rresp_sel;
      end
   end

   assign s_axi_awready = awready_q;
   assign s_axi_wready = wready_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
   assign diag_ready_status = stat_q;

   // Flag checks
   a_temp_rr_clear: assert property (@(posedge aclk) disable iff (!aresetn)
      clr_temp_rr && !temp_rr_pass_done |=> !stat_q[`DCS_BIT_TEMP_RR])
      else $error("temperature round-robin flag not cleared");
   a_temp_rr_set: assert property (@(posedge aclk) disable iff (!aresetn)
      temp_rr_pass_done |=> stat_q[`DCS_BIT_TEMP_RR])
      else $error("temperature round-robin flag not set");
   a_temp_rr_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      !temp_rr_pass_done |=> !$rose(stat_q[`DCS_BIT_TEMP_RR]))
      else $error("temperature round-robin flag rose without a pass");
   a_temp_rr_keep: assert property (@(posedge aclk) disable iff (!aresetn)
      !clr_temp_rr |=> !$fell(stat_q[`DCS_BIT_TEMP_RR]))
      else $error("temperature round-robin flag fell without a launch");
   a_mode_isolation: assert property (@(posedge aclk) disable iff (!aresetn)
      temp_cmp_go && temp_cmp_mode == `DCS_MODE_ST && stat_q[`DCS_BIT_TEMP_RR] |=> stat_q[`DCS_BIT_TEMP_RR])
      else $error("self-test launch disturbed round-robin flag");
   a_volt_rr_flag: assert property (@(posedge aclk) disable iff (!aresetn)
      clr_volt_rr && !volt_rr_pass_done ##1 !volt_rr_pass_done |=> !stat_q[`DCS_BIT_VOLT_RR])
      else $error("voltage round-robin flag wrong after launch");
   a_volt_rr_clear: assert property (@(posedge aclk) disable iff (!aresetn)
      clr_volt_rr && !volt_rr_pass_done |=> !stat_q[`DCS_BIT_VOLT_RR])
      else $error("voltage round-robin flag not cleared");
   a_volt_rr_set: assert property (@(posedge aclk) disable iff (!aresetn)
      volt_rr_pass_done |=> stat_q[`DCS_BIT_VOLT_RR])
      else $error("voltage round-robin flag not set");
   a_volt_rr_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      !volt_rr_pass_done |=> !$rose(stat_q[`DCS_BIT_VOLT_RR]))
      else $error("voltage round-robin flag rose without a pass");
   a_volt_rr_keep: assert property (@(posedge aclk) disable iff (!aresetn)
      !clr_volt_rr |=> !$fell(stat_q[`DCS_BIT_VOLT_RR]))
      else $error("voltage round-robin flag fell without a launch");
   a_volt_rr_isolation: assert property (@(posedge aclk) disable iff (!aresetn)
      volt_cmp_go && volt_cmp_mode == `DCS_MODE_ST && stat_q[`DCS_BIT_VOLT_RR] |=> stat_q[`DCS_BIT_VOLT_RR])
      else $error("self-test launch disturbed voltage round-robin flag");
   a_volt_st_clear: assert property (@(posedge aclk) disable iff (!aresetn)
      clr_volt_st && !volt_selftest_cycle_done |=> stat_q[`DCS_BIT_VOLT_ST] == 1'h0)
      else $error("voltage self-test flag not cleared");
   a_volt_st_keep: assert property (@(posedge aclk) disable iff (!aresetn)
      !clr_volt_st |=> !$fell(stat_q[`DCS_BIT_VOLT_ST]))
      else $error("voltage self-test flag fell without a launch");
   a_volt_st_isolation: assert property (@(posedge aclk) disable iff (!aresetn)
      volt_cmp_go && volt_cmp_mode == `DCS_MODE_RR && stat_q[`DCS_BIT_VOLT_ST] |=> stat_q[`DCS_BIT_VOLT_ST])
      else $error("round-robin launch disturbed voltage self-test flag");
   a_volt_st_set: assert property (@(posedge aclk) disable iff (!aresetn)
      volt_selftest_cycle_done |=> stat_q[`DCS_BIT_VOLT_ST])
      else $error("voltage self-test flag not set");
   a_volt_st_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      !volt_selftest_cycle_done |=> !$rose(stat_q[`DCS_BIT_VOLT_ST]))
      else $error("voltage self-test flag rose without completion");
   a_supply_st_flag: assert property (@(posedge aclk) disable iff (!aresetn)
      supply_selftest_go && !supply_selftest_cycle_done |=> !diag_ready_status[`DCS_BIT_SUPPLY_ST])
      else $error("supply self-test flag not cleared");
   a_supply_st_set: assert property (@(posedge aclk) disable iff (!aresetn)
      supply_selftest_cycle_done |=> diag_ready_status[`DCS_BIT_SUPPLY_ST])
      else $error("supply self-test flag not set");
   a_supply_st_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      !supply_selftest_cycle_done |=> !$rose(stat_q[`DCS_BIT_SUPPLY_ST]))
      else $error("supply self-test flag rose without completion");
   a_supply_st_keep: assert property (@(posedge aclk) disable iff (!aresetn)
      !supply_selftest_go |=> !$fell(stat_q[`DCS_BIT_SUPPLY_ST]))
      else $error("supply self-test flag fell without a launch");
   a_temp_st_flag: assert property (@(posedge aclk) disable iff (!aresetn)
      clr_temp_st && !temp_selftest_cycle_done |=> !stat_q[`DCS_BIT_TEMP_ST])
      else $error("temperature self-test flag not cleared");
   a_temp_st_set: assert property (@(posedge aclk) disable iff (!aresetn)
      temp_selftest_cycle_done |=> stat_q[`DCS_BIT_TEMP_ST])
      else $error("temperature self-test flag not set");
   a_temp_st_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      !temp_selftest_cycle_done |=> !$rose(stat_q[`DCS_BIT_TEMP_ST]))
      else $error("temperature self-test flag rose without completion");
   a_temp_st_keep: assert property (@(posedge aclk) disable iff (!aresetn)
      !clr_temp_st |=> !$fell(stat_q[`DCS_BIT_TEMP_ST]))
      else $error("temperature self-test flag fell without a launch");
   a_temp_st_isolation: assert property (@(posedge aclk) disable iff (!aresetn)
      temp_cmp_go && temp_cmp_mode == `DCS_MODE_RR && stat_q[`DCS_BIT_TEMP_ST] |=> stat_q[`DCS_BIT_TEMP_ST])
      else $error("round-robin launch disturbed temperature self-test flag");
   a_stat_reset: assert property (@(posedge aclk)
      !aresetn |=> stat_q == `DCS_STAT_RESET)
      else $error("status not cleared by reset");

   // Bus checks
   a_reset_axi: assert property (@(posedge aclk)
      !aresetn |=> awready_q && wready_q && arready_q && !bvalid_q && !rvalid_q)
      else $error("bus handshake not idle after reset");
   a_ar_single: assert property (@(posedge aclk) disable iff (!aresetn)
      ar_fire |-> !rvalid_q)
      else $error("read address taken while a read is pending");
   a_ar_answer: assert property (@(posedge aclk) disable iff (!aresetn)
      ar_fire |=> s_axi_rvalid)
      else $error("read not answered in the next cycle");
   a_ar_blocked: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_rvalid |-> !s_axi_arready)
      else $error("read address open while data is pending");
   a_r_release: assert property (@(posedge aclk) disable iff (!aresetn)
      r_done |=> !s_axi_rvalid && s_axi_arready)
      else $error("read channel not released after handshake");
   a_rd_hit_data: assert property (@(posedge aclk) disable iff (!aresetn)
      ar_fire && ar_hit |=> s_axi_rdata == {24'h000000, $past(stat_q)})
      else $error("read data differs from status");
   a_rd_hit_resp: assert property (@(posedge aclk) disable iff (!aresetn)
      ar_fire && ar_hit |=> s_axi_rresp == `DCS_RESP_OKAY)
      else $error("mapped read not answered with okay");
   a_rd_miss: assert property (@(posedge aclk) disable iff (!aresetn)
      ar_fire && !ar_hit |=> s_axi_rdata == 32'h00000000 && s_axi_rresp == `DCS_RESP_SLVERR)
      else $error("unmapped read not refused");
   a_rd_upper_zero: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
      else $error("read data has bits above the status byte");
   a_b_answer: assert property (@(posedge aclk) disable iff (!aresetn)
      b_start |=> s_axi_bvalid)
      else $error("write not answered in the next cycle");
   a_b_release: assert property (@(posedge aclk) disable iff (!aresetn)
      b_done |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
      else $error("write channels not released after response");
   a_aw_blocked: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write channels open while response is pending");
   a_bresp_err: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_bvalid |-> s_axi_bresp == `DCS_RESP_SLVERR)
      else $error("write not refused");

endmodule : dcs_diag_status

/* File: rtl/dcs_consts.svh */
// Purpose: Constants for the diagnostic completion status block
// Assumes: Byte addresses on a 32-bit AXI4-Lite bus
// Notes: Register index times four gives the byte address
`ifndef DCS_CONSTS_SVH
`define DCS_CONSTS_SVH
`define DCS_IDX_DIAG_READY_STATUS 12'h526
`define DCS_ADDR_DIAG_READY_STATUS 14'h1498
`define DCS_ADDR_W 14
`define DCS_STAT_RESET 8'h00
`define DCS_BIT_TEMP_RR 4
`define DCS_BIT_VOLT_RR 3
`define DCS_BIT_TEMP_ST 2
`define DCS_BIT_VOLT_ST 1
`define DCS_BIT_SUPPLY_ST 0
`define DCS_MODE_RR 2'h1
`define DCS_MODE_ST 2'h2
`define DCS_RESP_OKAY 2'h0
`define DCS_RESP_SLVERR 2'h2
`endif

/* File: rtl/dcs_pkg.sv */
// Purpose: Types for the diagnostic completion status block
// Assumes: Nothing beyond the constants header
// Notes: Holds the status word type only
package dcs_pkg;
   typedef logic [7:0] dcs_stat_t;
endpackage : dcs_pkg

/* File: bench/tb.sv */
// Purpose: Self-checking bench for the diagnostic completion status register
// Assumes: Single 100 MHz clock, synchronous active-low reset
// Notes: Flags are pulsed by go and done strobes, then read on the port and over AXI4-Lite
`timescale 1ns/100ps
`include "dcs_consts.svh"
module tb;
   localparam logic [2:0] GO_T [5] = '{3'h1, 3'h2, 3'h4, 3'h2, 3'h4};
   localparam logic [1:0] MD_T [5] = '{2'h0, `DCS_MODE_ST, `DCS_MODE_ST, `DCS_MODE_RR, `DCS_MODE_RR};
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [2:0] go = 3'h0;
   logic [1:0] tmode = 2'h0, vmode = 2'h0, bresp, rresp;
   logic [4:0] dn = 5'h0;
   logic [7:0] stat;
   int err_total = 0;
   int comparisons = 0;
   always #5 aclk = ~aclk;
   dcs_diag_status dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .temp_cmp_go(go[2]),
      .temp_cmp_mode(tmode), .volt_cmp_go(go[1]), .volt_cmp_mode(vmode), .supply_selftest_go(go[0]),
      .temp_rr_pass_done(dn[4]), .volt_rr_pass_done(dn[3]), .temp_selftest_cycle_done(dn[2]),
      .volt_selftest_cycle_done(dn[1]), .supply_selftest_cycle_done(dn[0]), .diag_ready_status(stat));
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         err_total++;
         $display("MISMATCH %s expected %0h seen %0h", n, e, g);
      end
   endtask : chk
   task end_of_test;
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : end_of_test
   task rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : rd
   task wr(input logic [31:0] a, output logic [1:0] r);
      @(posedge aclk);
      awaddr <= a;
      wdata <= 32'hFFFFFFFF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask : wr
   task ev(input logic [2:0] g, input logic [1:0] m, input logic [4:0] d);
      @(posedge aclk);
      go <= g;
      tmode <= m;
      vmode <= m;
      dn <= d;
      @(posedge aclk);
      go <= 3'h0;
      dn <= 5'h0;
      @(posedge aclk);
   endtask : ev
   task look(input logic [7:0] e);
      logic [31:0] d;
      logic [1:0] r;
      chk("status port", {24'h0, e}, {24'h0, stat});
      rd(`DCS_ADDR_DIAG_READY_STATUS, d, r);
      chk("status read", {24'h0, e}, d);
      chk("read resp", {30'h0, `DCS_RESP_OKAY}, {30'h0, r});
   endtask : look
   task t_flags;
      ev(3'h0, 2'h0, 5'h1F);
      look(8'h1F);
      for (int i = 0; i < 5; i++) begin
         if (i != 0) begin
            ev(GO_T[i], 2'h0, 5'h0);
            look(8'h1F);
            ev(GO_T[i], 2'h3, 5'h0);
            look(8'h1F);
         end
         ev(GO_T[i], MD_T[i], 5'h0);
         look(8'h1F & ~(8'h01 << i));
         ev(3'h0, 2'h0, 5'h01 << i);
         look(8'h1F);
      end
      $display("test flags done");
   endtask : t_flags
   task t_both;
      ev(3'h7, `DCS_MODE_RR, 5'h1F);
      look(8'h1F);
      ev(3'h7, `DCS_MODE_RR, 5'h00);
      look(8'h06);
      $display("test simultaneous done");
   endtask : t_both
   task t_bus;
      logic [31:0] d;
      logic [1:0] r;
      wr(`DCS_ADDR_DIAG_READY_STATUS, r);
      chk("write resp", {30'h0, `DCS_RESP_SLVERR}, {30'h0, r});
      look(8'h06);
      rd(32'h0, d, r);
      chk("unmapped data", 32'h0, d);
      chk("unmapped resp", {30'h0, `DCS_RESP_SLVERR}, {30'h0, r});
      $display("test bus done");
   endtask : t_bus
   task t_rst;
      @(posedge aclk);
      aresetn <= 1'h0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'h1;
      look(`DCS_STAT_RESET);
      ev(3'h0, 2'h0, 5'h1F);
      look(8'h1F);
      $display("test mid-run reset done");
   endtask : t_rst
   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      look(`DCS_STAT_RESET);
      $display("test reset done");
      t_flags;
      t_both;
      t_bus;
      t_rst;
      end_of_test;
   end
   initial begin
      repeat (5000) @(posedge aclk);
      err_total++;
      end_of_test;
   end
endmodule : tb
